// ==== rtl/pzs_pkg.sv ====
// Shared constants for the pipelined zero-turnaround SRAM model
package pzs_pkg;
  localparam int ADDR_W = 19;
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic MODE_LINEAR = 1'b0;
endpackage

// ==== rtl/pzs_sram.sv ====
// Pipelined burst SRAM with no turnaround cycles, device side
`timescale 1ns/10ps
module pzs_sram #(
  parameter int ADDR_W = pzs_pkg::ADDR_W,
  parameter int BYTES = pzs_pkg::BYTES,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command
  input wire logic clock_hold_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic advance_or_load,
  input wire logic rw_select_n,
  input wire logic [BYTES-1:0] byte_lane_select_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic burst_order,
  input wire logic output_drive_enable_n,
  // Data bus
  input wire logic [BYTES*pzs_pkg::BYTE_W-1:0] ioDataIn,
  output logic [BYTES*pzs_pkg::BYTE_W-1:0] ioDataOut,
  output logic ioDataOe,
  input wire logic [BYTES-1:0] ioParityIn,
  output logic [BYTES-1:0] ioParityOut,
  output logic ioParityOe
);
  localparam int DW = BYTES * pzs_pkg::BYTE_W;
  localparam int IDX_W = $clog2(DEPTH);
  initial begin
    if (DEPTH < 4 || DEPTH > (1 << ADDR_W) || BYTES < 1) begin
      $error("pzs_sram: unsupported parameters");
    end
  end

  function automatic logic [1:0] burstLow(input logic [1:0] start, input logic [1:0] beat,
                                          input logic order);
    burstLow = (order == pzs_pkg::MODE_LINEAR) ? 2'(start + beat) : (start ^ beat);
  endfunction

  // Input synchronisation for the asynchronous-facing pins
  logic oeS1_reg, oeS2_reg, oeS3_reg, oeFilt_reg;
  logic modeS1_reg, modeS2_reg, modeS3_reg, modeFilt_reg;

  // Pipeline state
  logic [ADDR_W-1:0] baseAddr_reg;
  logic [1:0] beat_reg;
  logic burstRead_reg;            // direction of current burst
  logic active_reg;               // a burst is open
  logic stage1Valid_reg, stage1Read_reg;
  logic [ADDR_W-1:0] stage1Addr_reg;
  logic [BYTES-1:0] stage1Bls_reg;
  logic stage2Read_reg, stage2Write_reg;
  logic [ADDR_W-1:0] stage2Addr_reg;
  logic [BYTES-1:0] stage2Bls_reg;
  logic drive_reg;
  // Read data gathered from the lanes
  wire logic [DW-1:0] laneDataOut;
  wire logic [BYTES-1:0] laneParOut;

  wire logic edgeOk = ~clock_hold_n;
  wire logic allSel = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
  wire logic loadCmd = edgeOk & ~advance_or_load;
  wire logic startCmd = loadCmd & allSel;
  wire logic deselCmd = loadCmd & ~allSel;
  wire logic advCmd = edgeOk & advance_or_load & active_reg;
  wire logic [1:0] beatNext = 2'(beat_reg + pzs_pkg::BURST_ONE);
  wire logic [ADDR_W-1:0] advAddr =
    {baseAddr_reg[ADDR_W-1:2], burstLow(baseAddr_reg[1:0], beatNext, modeFilt_reg)};
  wire logic [IDX_W-1:0] rdIdx = stage1Addr_reg[IDX_W-1:0];
  wire logic [IDX_W-1:0] wrIdx = stage2Addr_reg[IDX_W-1:0];

  always_ff @(posedge core_clk) begin
    oeS1_reg <= output_drive_enable_n;
    oeS2_reg <= oeS1_reg;
    oeS3_reg <= oeS2_reg;
    modeS1_reg <= burst_order;
    modeS2_reg <= modeS1_reg;
    modeS3_reg <= modeS2_reg;
    if (oeS2_reg == oeS3_reg) begin
      oeFilt_reg <= oeS3_reg;
    end
    if (modeS2_reg == modeS3_reg) begin
      modeFilt_reg <= modeS3_reg;
    end
  end

  // Address, burst and control pipeline
  always_ff @(posedge core_clk) begin
    if (rst) begin
      active_reg <= 1'b0;
      beat_reg <= pzs_pkg::BURST_ZERO;
      burstRead_reg <= 1'b0;
      baseAddr_reg <= '0;
      stage1Valid_reg <= 1'b0;
      stage1Read_reg <= 1'b0;
      stage1Addr_reg <= '0;
      stage1Bls_reg <= '1;
      stage2Read_reg <= 1'b0;
      stage2Write_reg <= 1'b0;
      stage2Addr_reg <= '0;
      stage2Bls_reg <= '1;
    end else if (edgeOk) begin
      stage2Read_reg <= stage1Valid_reg & stage1Read_reg;
      stage2Write_reg <= stage1Valid_reg & ~stage1Read_reg;
      stage2Addr_reg <= stage1Addr_reg;
      stage2Bls_reg <= stage1Bls_reg;
      if (startCmd) begin
        active_reg <= 1'b1;
        baseAddr_reg <= address;
        beat_reg <= pzs_pkg::BURST_ZERO;
        burstRead_reg <= rw_select_n;
        stage1Valid_reg <= 1'b1;
        stage1Read_reg <= rw_select_n;
        stage1Addr_reg <= address;
        stage1Bls_reg <= byte_lane_select_n;
      end else if (advCmd) begin
        beat_reg <= beatNext;
        stage1Valid_reg <= 1'b1;
        stage1Read_reg <= burstRead_reg;
        stage1Addr_reg <= advAddr;
        stage1Bls_reg <= byte_lane_select_n;
      end else begin
        if (deselCmd) begin
          active_reg <= 1'b0;
        end
        stage1Valid_reg <= 1'b0;
      end
    end
  end

  // Memory core per lane: read into output register, write at second edge
  for (genvar b = 0; b < BYTES; b++) begin : gLane
    logic [pzs_pkg::BYTE_W-1:0] laneMem [DEPTH];
    logic lanePar [DEPTH];
    logic [pzs_pkg::BYTE_W-1:0] laneOut_reg;
    logic laneParOut_reg;
    always_ff @(posedge core_clk) begin
      if (edgeOk && stage2Write_reg && !stage2Bls_reg[b]) begin
        laneMem[wrIdx] <= ioDataIn[b*pzs_pkg::BYTE_W +: pzs_pkg::BYTE_W];
        lanePar[wrIdx] <= ioParityIn[b];
      end
      if (edgeOk && stage1Valid_reg && stage1Read_reg) begin
        laneOut_reg <= laneMem[rdIdx];
        laneParOut_reg <= lanePar[rdIdx];
      end
    end
    assign laneDataOut[b*pzs_pkg::BYTE_W +: pzs_pkg::BYTE_W] = laneOut_reg;
    assign laneParOut[b] = laneParOut_reg;
  end

  // Drive window: from the first recognised edge after a read command to the next recognised edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_reg <= 1'b0;
    end else if (edgeOk) begin
      drive_reg <= stage1Valid_reg & stage1Read_reg;
    end
  end

  assign ioDataOut = laneDataOut;
  assign ioParityOut = laneParOut;
  assign ioDataOe = drive_reg & ~oeFilt_reg;
  assign ioParityOe = drive_reg & ~oeFilt_reg;

  // Checks
  property p_holdFreezes;
    @(posedge core_clk) disable iff (rst)
      clock_hold_n |=> $stable(beat_reg) && $stable(stage1Valid_reg) && $stable(drive_reg);
  endproperty
  a_holdFreezes: assert property (p_holdFreezes) else $error("hold edge changed state");

  property p_readDrive;
    @(posedge core_clk) disable iff (rst)
      startCmd && rw_select_n ##1 edgeOk |=> drive_reg;
  endproperty
  a_readDrive: assert property (p_readDrive) else $error("read data not driven");

  property p_writeFloat;
    @(posedge core_clk) disable iff (rst)
      startCmd && !rw_select_n ##1 edgeOk |=> !ioDataOe;
  endproperty
  a_writeFloat: assert property (p_writeFloat) else $error("driving during write");

  property p_deselFloat;
    @(posedge core_clk) disable iff (rst)
      deselCmd ##1 edgeOk |=> !ioDataOe;
  endproperty
  a_deselFloat: assert property (p_deselFloat) else $error("driving after deselect");

  property p_advKeepsDir;
    @(posedge core_clk) disable iff (rst)
      advCmd && !startCmd |=> stage1Valid_reg && stage1Read_reg == $past(burstRead_reg);
  endproperty
  a_advKeepsDir: assert property (p_advKeepsDir) else $error("burst direction lost");

  property p_beatWrap;
    @(posedge core_clk) disable iff (rst)
      advCmd |=> beat_reg == 2'($past(beat_reg) + 2'h1);
  endproperty
  a_beatWrap: assert property (p_beatWrap) else $error("burst counter wrong");

  property p_oeGate;
    @(posedge core_clk) disable iff (rst)
      oeFilt_reg |-> !ioDataOe && !ioParityOe;
  endproperty
  a_oeGate: assert property (p_oeGate) else $error("drive with enable high");

  property p_linearOrder;
    @(posedge core_clk) disable iff (rst)
      advCmd && !modeFilt_reg |=>
        stage1Addr_reg[1:0] == 2'(baseAddr_reg[1:0] + beat_reg);
  endproperty
  a_linearOrder: assert property (p_linearOrder) else $error("linear order wrong");

  property p_interOrder;
    @(posedge core_clk) disable iff (rst)
      advCmd && modeFilt_reg |=> stage1Addr_reg[1:0] == (baseAddr_reg[1:0] ^ beat_reg);
  endproperty
  a_interOrder: assert property (p_interOrder) else $error("interleaved order wrong");

  property p_resetFloat;
    @(posedge core_clk)
      rst |=> !ioDataOe && !ioParityOe;
  endproperty
  a_resetFloat: assert property (p_resetFloat) else $error("driving after reset");

  property p_leaveDesel;
    @(posedge core_clk) disable iff (rst)
      deselCmd ##1 (edgeOk && startCmd) |=> !ioDataOe;
  endproperty
  a_leaveDesel: assert property (p_leaveDesel) else $error("driving leaving deselect");

  property p_deselClose;
    @(posedge core_clk) disable iff (rst)
      deselCmd |=> !active_reg;
  endproperty
  a_deselClose: assert property (p_deselClose) else $error("burst left open");

  property p_advIgnored;
    @(posedge core_clk) disable iff (rst)
      edgeOk && advance_or_load && !active_reg |=> !stage1Valid_reg;
  endproperty
  a_advIgnored: assert property (p_advIgnored) else $error("advance with no burst");

  property p_loadCapture;
    @(posedge core_clk) disable iff (rst)
      startCmd |=> stage1Valid_reg && stage1Addr_reg == $past(address) &&
        stage1Bls_reg == $past(byte_lane_select_n);
  endproperty
  a_loadCapture: assert property (p_loadCapture) else $error("load not captured");

  property p_writeStage;
    @(posedge core_clk) disable iff (rst)
      startCmd && !rw_select_n ##1 edgeOk |=> stage2Write_reg;
  endproperty
  a_writeStage: assert property (p_writeStage) else $error("write not staged");

  property p_backToBack;
    @(posedge core_clk) disable iff (rst)
      startCmd && rw_select_n ##1 startCmd |=> drive_reg && stage1Valid_reg;
  endproperty
  a_backToBack: assert property (p_backToBack) else $error("back to back lost");

  property p_holdData;
    @(posedge core_clk) disable iff (rst)
      clock_hold_n && drive_reg |=> $stable(ioDataOut);
  endproperty
  a_holdData: assert property (p_holdData) else $error("output changed on hold");

  property p_holdStages;
    @(posedge core_clk) disable iff (rst)
      clock_hold_n |=> $stable(stage2Write_reg) && $stable(active_reg);
  endproperty
  a_holdStages: assert property (p_holdStages) else $error("hold edge moved pipeline");

  c_readBack: cover property (@(posedge core_clk) disable iff (rst)
    startCmd && rw_select_n ##2 ioDataOe);
  c_burst4: cover property (@(posedge core_clk) disable iff (rst)
    startCmd ##1 advCmd ##1 advCmd ##1 advCmd);
  c_writeRead: cover property (@(posedge core_clk) disable iff (rst)
    startCmd && !rw_select_n ##1 startCmd && rw_select_n);
  c_interleaved: cover property (@(posedge core_clk) disable iff (rst)
    advCmd && modeFilt_reg);
  c_holdRead: cover property (@(posedge core_clk) disable iff (rst)
    startCmd && rw_select_n ##1 clock_hold_n);
endmodule

// ==== tb/pzs_host.sv ====
// Host controller model issuing one queued command per clock
`timescale 1ns/10ps
module pzs_host (
  // Clock
  input wire logic core_clk,
  // Command
  output logic clock_hold_n,
  output logic chip_select_1_n,
  output logic chip_select_2,
  output logic chip_select_3_n,
  output logic advance_or_load,
  output logic rw_select_n,
  output logic [3:0] byte_lane_select_n,
  output logic [18:0] address,
  output logic output_drive_enable_n,
  // Write data
  output logic [31:0] ioDataIn,
  output logic [3:0] ioParityIn
);
  localparam logic [65:0] IDLE = {2'h0, 3'h7, 61'h0};
  logic [65:0] cmdQ[$];
  logic [65:0] cur = IDLE;
  logic [65:0] due = IDLE;
  logic rec;
  logic oeOff = 1'b0;
  assign output_drive_enable_n = oeOff;
  assign {clock_hold_n, advance_or_load, chip_select_1_n, chip_select_2, chip_select_3_n,
    rw_select_n, byte_lane_select_n, address} = {cur[65], cur[64:37]};
  initial {ioParityIn, ioDataIn} = 36'h0;
  // Data goes out one recognised edge after its command was taken
  always @(posedge core_clk) begin
    rec = !clock_hold_n;
    #1;
    if (rec) begin
      {ioParityIn, ioDataIn} <= due[36] ? due[35:0] : ~{ioParityIn, ioDataIn};
      due = cur;
    end
    cur = cmdQ.size() > 0 ? cmdQ.pop_front() : IDLE;
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the pipelined burst SRAM
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic burst_order = 1'b0;
  logic clock_hold_n, chip_select_1_n, chip_select_2, chip_select_3_n, advance_or_load;
  logic rw_select_n, output_drive_enable_n, ioDataOe, ioParityOe, lastRec, open, burstWr;
  logic [3:0] byte_lane_select_n, ioParityIn, ioParityOut;
  logic [18:0] address;
  logic [31:0] ioDataIn, ioDataOut;
  logic [15:0] lfsrState = 16'hB5BA;
  logic [35:0] expQ[$];
  logic [35:0] mem[64];
  logic [5:0] startA;
  logic [1:0] beat;
  int badCount = 0;
  int checked = 0;

  pzs_host pzs_host_inst (
    .core_clk(core_clk),
    .clock_hold_n(clock_hold_n),
    .chip_select_1_n(chip_select_1_n),
    .chip_select_2(chip_select_2),
    .chip_select_3_n(chip_select_3_n),
    .advance_or_load(advance_or_load),
    .rw_select_n(rw_select_n),
    .byte_lane_select_n(byte_lane_select_n),
    .address(address),
    .output_drive_enable_n(output_drive_enable_n),
    .ioDataIn(ioDataIn),
    .ioParityIn(ioParityIn)
  );
  pzs_sram #(.DEPTH(64)) pzs_sram_inst (
    .core_clk(core_clk),
    .rst(rst),
    .clock_hold_n(clock_hold_n),
    .chip_select_1_n(chip_select_1_n),
    .chip_select_2(chip_select_2),
    .chip_select_3_n(chip_select_3_n),
    .advance_or_load(advance_or_load),
    .rw_select_n(rw_select_n),
    .byte_lane_select_n(byte_lane_select_n),
    .address(address),
    .burst_order(burst_order),
    .output_drive_enable_n(output_drive_enable_n),
    .ioDataIn(ioDataIn),
    .ioDataOut(ioDataOut),
    .ioDataOe(ioDataOe),
    .ioParityIn(ioParityIn),
    .ioParityOut(ioParityOut),
    .ioParityOe(ioParityOe)
  );

  initial forever #25 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr();
    lfsrState = {lfsrState[14:0], ^(lfsrState & 16'hB400)};
    return lfsrState;
  endfunction

  task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // Queue one command and predict its effect on memory and read data
  task automatic op(input logic ld, input logic [2:0] cs, input logic rw, input logic [5:0] a,
      input logic [3:0] m);
    logic [47:0] r;
    logic [3:0] b;
    logic [5:0] wa;
    r = {lfsr(), lfsr(), lfsr()};
    b = r[39:36] & m;
    if (!ld) begin
      open = cs == 3'h2;
      startA = a;
      beat = 2'h0;
      burstWr = !rw;
    end else if (open) beat++;
    wa = {startA[5:2], burst_order ? startA[1:0] ^ beat : startA[1:0] + beat};
    if (open && burstWr) begin
      for (int i = 0; i < 4; i++) begin
        if (!b[i]) begin
          mem[wa][8*i +: 8] = r[8*i +: 8];
          mem[wa][32+i] = r[32+i];
        end
      end
    end else if (open) expQ.push_back(mem[wa]);
    pzs_host_inst.cmdQ.push_back({1'b0, ld, cs, rw, b, 13'h0, a, open && burstWr, r[35:0]});
  endtask

  task automatic hold();
    pzs_host_inst.cmdQ.push_back({2'h2, lfsr(), lfsr(), lfsr(), lfsr()});
  endtask

  task automatic drain();
    while (pzs_host_inst.cmdQ.size() > 0) @(posedge core_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Monitor takes read words only in cycles that follow a recognised edge
  always @(posedge core_clk) lastRec = clock_hold_n === 1'b0;
  always @(negedge core_clk) begin
    cmp("parityOe", {35'h0, ioDataOe}, {35'h0, ioParityOe});
    if (ioDataOe === 1'b1 && lastRec) begin
      if (expQ.size() == 0) cmp("dataOe", 36'h0, 36'h1);
      else cmp("readWord", expQ.pop_front(), {ioParityOut, ioDataOut});
    end
  end

  initial begin
    logic [15:0] r;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 32; i++) op(1'b0, 3'h2, 1'b0, i[5:0], 4'h0);
    for (int m = 0; m < 2; m++) begin
      drain();
      burst_order = m[0];
      repeat (6) op(1'b0, 3'h7, 1'b1, 6'h0, 4'hF);
      r = lfsr();
      op(1'b0, 3'h2, 1'b0, {1'b0, r[4:0]}, 4'hF);
      repeat (3) op(1'b1, lfsrState[2:0], lfsrState[3], lfsrState[5:0], 4'hF);
      repeat (2) op(1'b0, 3'h5, 1'b1, 6'h0, 4'hF);
      op(1'b0, 3'h2, 1'b1, {1'b0, r[4:0]}, 4'hF);
      hold();
      repeat (4) op(1'b1, lfsrState[2:0], lfsrState[3], lfsrState[5:0], 4'hF);
      repeat (2) op(1'b0, 3'h3, 1'b1, 6'h0, 4'hF);
    end
    // Writes stay in the upper half, reads in the prefilled lower half
    repeat (150) begin
      r = lfsr();
      if (r[9:8] == 2'h0) hold();
      op(r[6] & r[5], r[7] ? 3'h2 : r[2:0], r[3], {!r[3], r[4:0]}, 4'hF);
    end
    drain();
    repeat (5) @(posedge core_clk);
    cmp("pendingReads", 36'h0, 36'(expQ.size()));
    // Enable released: a read must leave the bus floating
    #1 pzs_host_inst.oeOff = 1'b1;
    repeat (5) @(posedge core_clk);
    pzs_host_inst.cmdQ.push_back({1'b0, 1'b0, 3'h2, 1'b1, 4'hF, 13'h0, 6'h0, 37'h0});
    repeat (4) begin
      @(negedge core_clk);
      cmp("oeMasked", 36'h0, {35'h0, ioDataOe});
    end
    report_and_stop();
  end

  initial begin
    #(3000 * 50);
    badCount++;
    report_and_stop();
  end
endmodule
